// File: src/input_filter_regs.svh
// Purpose: Constants for the input filter and output select block.
// Assumes: core_clk at 125 MHz.
// Notes: Times are in ns; cycle counts derive from them.
`ifndef INPUT_FILTER_REGS_SVH
`define INPUT_FILTER_REGS_SVH
`define CLK_PERIOD_NS 8
`define GLITCH_MAX_NS 100000
`define GLITCH_MAX_CYC (`GLITCH_MAX_NS / `CLK_PERIOD_NS)
`define PULSE_MAX_NS 100000
`define PULSE_MAX_CYC (`PULSE_MAX_NS / `CLK_PERIOD_NS)
`define OSC_PERIOD_NS 10000
`define OSC_HALF_CYC ((`OSC_PERIOD_NS / `CLK_PERIOD_NS) / 2)
`define TIME_W 14
`define NUM_DIRECT 5
`define NUM_DUAL 5
`define NUM_OUT 10
`define NUM_HIGH_DRIVE 6
`define SRC_W 2
`define DRIVE_W 3
`define RESET_SRC 2'h0
`define RESET_DRIVE 3'h0
`endif

// File: src/input_filter_pkg.sv
// Purpose: Types shared by the input filter and output select block.
// Assumes: Constants come from input_filter_regs.svh.
// Notes: Source code 0 selects the state machine so an all-zero config is safe.
package input_filter_pkg;
   typedef enum logic [1:0] {
      SRC_STATE_MACHINE = 2'h0,
      SRC_SMBUS = 2'h1,
      SRC_CLOCK = 2'h2,
      SRC_RESERVED = 2'h3
   } out_src_t;
   typedef enum logic [2:0] {
      DRV_WEAK_PULLDOWN = 3'h0,
      DRV_OPEN_DRAIN = 3'h1,
      DRV_OD_WEAK_VDD = 3'h2,
      DRV_OD_STRONG_VDD = 3'h3,
      DRV_OD_WEAK_VP = 3'h4,
      DRV_OD_STRONG_VP = 3'h5,
      DRV_STRONG_PULLDOWN = 3'h6,
      DRV_CHARGE_PUMP = 3'h7
   } drive_mode_t;
   typedef struct packed {
      logic [4:0] digital_mode;
      logic [4:0] edge_mode;
      logic [4:0] input_enable;
      logic [13:0] glitch_cycles;
      logic [13:0] pulse_cycles;
   } input_cfg_t;
   typedef struct packed {
      out_src_t [9:0] source;
      drive_mode_t [9:0] drive;
      logic [9:0] smbus_value;
   } output_cfg_t;
   typedef struct packed {
      logic [9:0] level;
      drive_mode_t [9:0] drive;
   } pin_drive_t;
endpackage

// File: src/glitch_filter.sv
// Purpose: Time-domain glitch filter for one comparator or logic input.
// Assumes: Input is already in the core_clk domain.
// Notes: Output follows input after it has been stable for timeout cycles.
`timescale 1ns/100ps
`include "input_filter_regs.svh"
module glitch_filter #(
   parameter int TIME_W = `TIME_W
) (
   // Clocking.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Filter data.
   input wire logic [TIME_W-1:0] timeout,
   input wire logic din,
   output logic dout
);
   logic [TIME_W-1:0] count_ff;
   logic [TIME_W-1:0] nxt_count;
   logic last_ff;
   logic nxt_last;
   logic dout_ff;
   logic nxt_dout;

   always_comb begin
      nxt_last = din;
      nxt_count = count_ff;
      nxt_dout = dout_ff;
      if (din != last_ff) begin
         nxt_count = '0;
      end else if (count_ff < timeout) begin
         nxt_count = count_ff + 1'b1;
      end
      if (timeout == '0) begin
         nxt_dout = din;
      end else if (din == last_ff && count_ff == timeout - 1'b1) begin
         nxt_dout = din;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_ff <= '0;
         last_ff <= 1'b0;
         dout_ff <= 1'b0;
      end else if (clk_en) begin
         count_ff <= nxt_count;
         last_ff <= nxt_last;
         dout_ff <= nxt_dout;
      end
   end

   assign dout = dout_ff;
endmodule

// File: src/input_filter_output_select.sv
// Purpose: Filters supervisor inputs and selects driver output sources.
// Assumes: Comparator results and logic pins arrive asynchronously.
// Notes: Configuration is latched when cfg_load pulses after supply is good.
// Overview of operation
// - glitch filter per fault comparator, to 100us
// - pulses shorter than timeout are dropped
// - pulses longer than timeout pass through
// - output lags input by the timeout
// - dual input detector has one range
// - logic-mode dual detector warns on dedicated input
// - warning detector shares range, signals warnings
// - warning outputs readable as status
// - all warnings ORed to state machine
// - five logic inputs, level or edge
// - level mode follows filtered input
// - edge mode emits programmable pulse width
// - logic inputs share the glitch filter
// - eight drive options, pump on first six
// - source is machine, SMBus or clock
// - SMBus source follows written value
// - internal 100 kHz clock for outputs
// - reset config zero, outputs weakly low
// - latch config after supply good only
// - machine levels held per state
`timescale 1ns/100ps
`include "input_filter_regs.svh"
module input_filter_output_select
   import input_filter_pkg::*;
#(
   parameter int NUM_DUAL = `NUM_DUAL,
   parameter int NUM_OUT = `NUM_OUT,
   parameter int TIME_W = `TIME_W
) (
   // Clocking.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Supply-good and configuration load.
   input wire logic supply_good,
   input wire logic cfg_load,
   input wire input_filter_pkg::input_cfg_t cfg_in,
   input wire input_filter_pkg::output_cfg_t out_cfg_in,
   // Comparator and pin inputs.
   input wire logic [4:0] supply_fault_detector,
   input wire logic [4:0] dual_function_input,
   input wire logic [4:0] dual_analog_fault,
   // State machine side.
   input wire logic [9:0] state_machine_core,
   output logic [4:0] fault_filtered,
   output logic [4:0] logic_input,
   output logic warning_any,
   output logic [4:0] warning_status,
   // Output pins.
   output input_filter_pkg::pin_drive_t driver_output,
   output logic cfg_latched
);
   import input_filter_pkg::*;

   localparam logic [TIME_W-1:0] GLITCH_MAX = TIME_W'(`GLITCH_MAX_CYC);
   localparam logic [TIME_W-1:0] PULSE_MAX = TIME_W'(`PULSE_MAX_CYC);
   localparam logic [TIME_W-1:0] OSC_HALF = TIME_W'(`OSC_HALF_CYC);

   function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] t,
                                                    input logic [TIME_W-1:0] lim);
      clamp_time = (t > lim) ? lim : t;
   endfunction

   // Two-stage synchronisers for all asynchronous inputs.
   logic [14:0] sync1_ff;
   logic [14:0] sync2_ff;
   logic [14:0] nxt_sync1;
   logic [14:0] nxt_sync2;
   logic supply_sync1_ff;
   logic supply_sync2_ff;
   logic nxt_supply_sync1;
   logic nxt_supply_sync2;

   always_comb begin
      nxt_sync1 = {dual_analog_fault, dual_function_input, supply_fault_detector};
      nxt_sync2 = sync1_ff;
      nxt_supply_sync1 = supply_good;
      nxt_supply_sync2 = supply_sync1_ff;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         supply_sync1_ff <= 1'b0;
         supply_sync2_ff <= 1'b0;
      end else if (clk_en) begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         supply_sync1_ff <= nxt_supply_sync1;
         supply_sync2_ff <= nxt_supply_sync2;
      end
   end

   // Configuration latch; everything is zero until supply is good.
   input_cfg_t icfg_ff;
   input_cfg_t nxt_icfg;
   output_cfg_t ocfg_ff;
   output_cfg_t nxt_ocfg;
   logic latched_ff;
   logic nxt_latched;

   always_comb begin
      nxt_icfg = icfg_ff;
      nxt_ocfg = ocfg_ff;
      nxt_latched = latched_ff;
      if (cfg_load && supply_sync2_ff) begin
         nxt_icfg = cfg_in;
         nxt_icfg.glitch_cycles = clamp_time(cfg_in.glitch_cycles, GLITCH_MAX);
         nxt_icfg.pulse_cycles = clamp_time(cfg_in.pulse_cycles, PULSE_MAX);
         nxt_ocfg = out_cfg_in;
         nxt_latched = 1'b1;
      end else if (latched_ff) begin
         nxt_ocfg.smbus_value = out_cfg_in.smbus_value;
      end
      for (int i = `NUM_HIGH_DRIVE; i < NUM_OUT; i++) begin
         if (nxt_ocfg.drive[i] == DRV_CHARGE_PUMP) begin
            nxt_ocfg.drive[i] = DRV_WEAK_PULLDOWN;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         icfg_ff <= '0;
         ocfg_ff <= '0;
         latched_ff <= 1'b0;
      end else if (clk_en) begin
         icfg_ff <= nxt_icfg;
         ocfg_ff <= nxt_ocfg;
         latched_ff <= nxt_latched;
      end
   end

   logic [14:0] filt;
   for (genvar g = 0; g < 15; g++) begin : g_filt
      glitch_filter #(.TIME_W(TIME_W)) u_filt (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .clk_en(clk_en),
         .timeout(icfg_ff.glitch_cycles),
         .din(sync2_ff[g]),
         .dout(filt[g])
      );
   end

   // Logic-input level and edge handling.
   logic [4:0] prev_ff;
   logic [4:0] nxt_prev;
   logic [TIME_W-1:0] pulse_cnt_ff [5];
   logic [TIME_W-1:0] nxt_pulse_cnt [5];
   logic [4:0] logic_ff;
   logic [4:0] nxt_logic;
   logic [4:0] fault_ff;
   logic [4:0] nxt_fault;
   logic [4:0] warn_ff;
   logic [4:0] nxt_warn;
   logic warn_any_ff;
   logic nxt_warn_any;

   always_comb begin
      nxt_prev = filt[9:5];
      nxt_fault = filt[4:0];
      nxt_logic = '0;
      nxt_warn = '0;
      for (int i = 0; i < 5; i++) begin
         nxt_pulse_cnt[i] = pulse_cnt_ff[i];
         if (icfg_ff.digital_mode[i] && icfg_ff.input_enable[i]) begin
            if (!icfg_ff.edge_mode[i]) begin
               nxt_logic[i] = filt[5 + i];
               nxt_pulse_cnt[i] = '0;
            end else begin
               if (filt[5 + i] != prev_ff[i]) begin
                  nxt_pulse_cnt[i] = icfg_ff.pulse_cycles;
               end else if (pulse_cnt_ff[i] != '0) begin
                  nxt_pulse_cnt[i] = pulse_cnt_ff[i] - 1'b1;
               end
               nxt_logic[i] = (nxt_pulse_cnt[i] != '0);
            end
         end else begin
            nxt_pulse_cnt[i] = '0;
         end
         if (icfg_ff.digital_mode[i]) begin
            nxt_warn[i] = filt[10 + i];
         end
      end
      nxt_warn_any = |nxt_warn;
   end

   // analog use of dual input is a plain fault detector.
   logic [4:0] dual_fault;
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         dual_fault[i] = !icfg_ff.digital_mode[i] && filt[10 + i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prev_ff <= '0;
         logic_ff <= '0;
         fault_ff <= '0;
         warn_ff <= '0;
         warn_any_ff <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            pulse_cnt_ff[i] <= '0;
         end
      end else if (clk_en) begin
         prev_ff <= nxt_prev;
         logic_ff <= nxt_logic;
         fault_ff <= nxt_fault;
         warn_ff <= nxt_warn;
         warn_any_ff <= nxt_warn_any;
         for (int i = 0; i < 5; i++) begin
            pulse_cnt_ff[i] <= nxt_pulse_cnt[i];
         end
      end
   end

   logic [TIME_W-1:0] osc_cnt_ff;
   logic [TIME_W-1:0] nxt_osc_cnt;
   logic osc_ff;
   logic nxt_osc;

   always_comb begin
      nxt_osc_cnt = osc_cnt_ff + 1'b1;
      nxt_osc = osc_ff;
      if (osc_cnt_ff == OSC_HALF - 1'b1) begin
         nxt_osc_cnt = '0;
         nxt_osc = !osc_ff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         osc_cnt_ff <= '0;
         osc_ff <= 1'b0;
      end else if (clk_en) begin
         osc_cnt_ff <= nxt_osc_cnt;
         osc_ff <= nxt_osc;
      end
   end

   // Output source selection.
   pin_drive_t drv_ff;
   pin_drive_t nxt_drv;

   always_comb begin
      nxt_drv = '0;
      for (int i = 0; i < NUM_OUT; i++) begin
         unique case (ocfg_ff.source[i])
            SRC_STATE_MACHINE: nxt_drv.level[i] = state_machine_core[i];
            SRC_SMBUS: nxt_drv.level[i] = ocfg_ff.smbus_value[i];
            SRC_CLOCK: nxt_drv.level[i] = osc_ff;
            SRC_RESERVED: nxt_drv.level[i] = 1'b0;
         endcase
         if (latched_ff) begin
            nxt_drv.drive[i] = ocfg_ff.drive[i];
         end else begin
            nxt_drv.level[i] = 1'b0;
            nxt_drv.drive[i] = DRV_WEAK_PULLDOWN;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         drv_ff <= '0;
      end else if (clk_en) begin
         drv_ff <= nxt_drv;
      end
   end

   assign warning_status = warn_ff;
   assign warning_any = warn_any_ff;
   assign fault_filtered = fault_ff;
   assign logic_input = logic_ff;
   assign driver_output = drv_ff;
   assign cfg_latched = latched_ff;
endmodule

// File: verification/ifos_asserts.sv
// Purpose: Port-level checks of the input filter and output select block.
// Assumes: Filter and pulse checks arm only for glitch 20 and pulse 6 cycles.
// Notes: Bound to the top module after the checker.
`timescale 1ns/100ps
module ifos_asserts
   import input_filter_pkg::*;
(
   // Clocking and configuration.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cfg_load,
   input wire input_filter_pkg::input_cfg_t cfg_in,
   input wire input_filter_pkg::output_cfg_t out_cfg_in,
   input wire logic [9:0] state_machine_core,
   input wire logic [4:0] supply_fault_detector,
   // Observed outputs.
   input wire logic [4:0] fault_filtered,
   input wire logic [4:0] logic_input,
   input wire input_filter_pkg::pin_drive_t driver_output,
   input wire logic cfg_latched
);
   logic [11:0] gap_ff;
   logic [11:0] nxt_gap;
   logic [1:0] seen_ff;
   logic [1:0] nxt_seen;
   logic lvl_ff;
   logic tog;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // Counts cycles between toggles of the clock-sourced output.
   always_comb begin
      tog = lvl_ff != driver_output.level[2];
      nxt_gap = tog ? 12'h000 : gap_ff + 12'h001;
      nxt_seen = (tog && seen_ff != 2'h3) ? seen_ff + 2'h1 : seen_ff;
   end
   always_ff @(posedge core_clk) begin
      lvl_ff <= rst_n ? driver_output.level[2] : 1'b0;
      gap_ff <= rst_n ? nxt_gap : 12'h000;
      seen_ff <= rst_n ? nxt_seen : 2'h0;
   end
   chk_idle_quiet: assert property (!cfg_latched |-> driver_output == '0 && logic_input == '0)
      else $error("outputs active before configuration latched");
   chk_latch_cause: assert property ($rose(cfg_latched) |-> $past(cfg_load))
      else $error("configuration latched without a load");
   chk_pump_limit: assert property (driver_output.drive[9] != DRV_CHARGE_PUMP && driver_output.drive[8] != DRV_CHARGE_PUMP && driver_output.drive[7] != DRV_CHARGE_PUMP && driver_output.drive[6] != DRV_CHARGE_PUMP)
      else $error("charge pump on an upper output");
   chk_filter_cause: assert property (cfg_latched && cfg_in.glitch_cycles == 14'h0014 && $rose(fault_filtered[0]) |-> $past(supply_fault_detector[0], 8) && $past(supply_fault_detector[0], 24))
      else $error("filtered fault rose without a held input");
   chk_edge_width: assert property (cfg_latched && cfg_in.edge_mode[1] && cfg_in.digital_mode[1] && cfg_in.pulse_cycles == 14'h0006 && $rose(logic_input[1]) |-> logic_input[1][*6] ##1 !logic_input[1])
      else $error("edge pulse width wrong");
   chk_smbus_track: assert property ((cfg_latched && out_cfg_in.source[1] == SRC_SMBUS && $stable(out_cfg_in.smbus_value[1]))[*3] |-> driver_output.level[1] == out_cfg_in.smbus_value[1])
      else $error("output does not follow written value");
   chk_sm_track: assert property ((cfg_latched && out_cfg_in.source[0] == SRC_STATE_MACHINE && $stable(state_machine_core[0]))[*3] |-> driver_output.level[0] == state_machine_core[0])
      else $error("output does not follow state machine");
   chk_clock_half: assert property (seen_ff >= 2'h2 && tog && cfg_latched && out_cfg_in.source[2] == SRC_CLOCK |-> gap_ff == 12'h270)
      else $error("clock output half period wrong");
   cover property ($rose(cfg_latched));
   cover property ($rose(fault_filtered[0]));
   cover property ($rose(logic_input[1]));
endmodule
bind input_filter_output_select ifos_asserts i_ifos_asserts (.core_clk(core_clk), .rst_n(rst_n),
   .cfg_load(cfg_load), .cfg_in(cfg_in), .out_cfg_in(out_cfg_in),
   .state_machine_core(state_machine_core), .supply_fault_detector(supply_fault_detector),
   .fault_filtered(fault_filtered), .logic_input(logic_input), .driver_output(driver_output),
   .cfg_latched(cfg_latched));

// File: verification/rail_model.sv
// Purpose: Supply comparators and external logic pins seen by the block.
// Assumes: Levels change just after a clock edge.
// Notes: Pins are always driven, so no floating level appears.
`timescale 1ns/100ps
module rail_model (
   // Clocking.
   input wire logic core_clk,
   // Comparator and pin levels.
   output logic [4:0] fault,
   output logic [4:0] pin,
   output logic [4:0] analog
);
   initial begin
      fault = 5'h00;
      pin = 5'h00;
      analog = 5'h00;
   end
   task automatic set_lv(input logic [4:0] f, input logic [4:0] p, input logic [4:0] a);
      @(posedge core_clk);
      fault <= f;
      pin <= p;
      analog <= a;
   endtask
endmodule

// File: verification/testbench.sv
// Purpose: Self-checking bench for the input filter and output select block.
// Assumes: Glitch 20 cycles, edge pulse 6 cycles, clock half period 625.
// Notes: Pins 0..3 are logic inputs, pin 3 disabled, pin 4 analog.
`timescale 1ns/100ps
module testbench;
   import input_filter_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic supply_good = 1'b0;
   logic cfg_load = 1'b0;
   input_cfg_t cfg_in;
   output_cfg_t out_cfg_in;
   logic [9:0] sm = 10'h001;
   logic [4:0] fault;
   logic [4:0] pin;
   logic [4:0] analog;
   logic [4:0] f_out;
   logic [4:0] l_out;
   logic [4:0] w_stat;
   logic w_any;
   logic latched;
   logic x;
   pin_drive_t drv;
   int error_cnt = 0;
   int n_tests = 0;
   int n;
   always #4 core_clk = ~core_clk;
   rail_model i_rail_model (.core_clk(core_clk), .fault(fault), .pin(pin), .analog(analog));
   input_filter_output_select i_input_filter_output_select (.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(1'b1), .supply_good(supply_good), .cfg_load(cfg_load), .cfg_in(cfg_in),
      .out_cfg_in(out_cfg_in), .supply_fault_detector(fault), .dual_function_input(pin),
      .dual_analog_fault(analog), .state_machine_core(sm), .fault_filtered(f_out),
      .logic_input(l_out), .warning_any(w_any), .warning_status(w_stat),
      .driver_output(drv), .cfg_latched(latched));
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic load();
      @(posedge core_clk);
      cfg_load <= 1'b1;
      @(posedge core_clk);
      cfg_load <= 1'b0;
      tick(2);
   endtask
   task automatic t_config();
      chk(drv, 40'h0);
      load();
      chk(latched, 1'b0);
      @(posedge core_clk);
      supply_good <= 1'b1;
      tick(4);
      load();
      chk(latched, 1'b1);
      chk(drv.drive[9], DRV_WEAK_PULLDOWN);
      chk(drv.drive[0], DRV_CHARGE_PUMP);
      chk(drv.level[3:0], 4'h3);
   endtask
   task automatic t_filter();
      i_rail_model.set_lv(5'h01, 5'h00, 5'h00);
      tick(9);
      i_rail_model.set_lv(5'h00, 5'h00, 5'h00);
      n = 0;
      repeat (40) begin
         tick(1);
         n += f_out[0];
      end
      chk(n, 0);
      i_rail_model.set_lv(5'h01, 5'h00, 5'h00);
      n = 0;
      while (f_out[0] !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      chk(n >= 20 && n <= 25, 1'b1);
   endtask
   task automatic t_logic(input logic [4:0] p);
      i_rail_model.set_lv(5'h00, p, 5'h00);
      n = 0;
      repeat (40) begin
         tick(1);
         n += l_out[1];
      end
      chk(n, 6);
      chk(l_out, {3'h0, p[1] & 1'b0, p[0]});
      chk(l_out[3], 1'b0);
   endtask
   task automatic t_warn();
      i_rail_model.set_lv(5'h00, 5'h00, 5'h11);
      tick(30);
      chk({w_any, w_stat}, 6'h21);
      i_rail_model.set_lv(5'h00, 5'h00, 5'h00);
      tick(30);
      chk({w_any, w_stat}, 6'h00);
   endtask
   task automatic t_outputs();
      x = drv.level[2];
      n = 0;
      while (drv.level[2] === x && n < 700) begin
         tick(1);
         n++;
      end
      repeat (2) begin
         x = drv.level[2];
         n = 0;
         while (drv.level[2] === x && n < 700) begin
            tick(1);
            n++;
         end
         chk(n, 625);
      end
      x = drv.level[2];
      @(posedge core_clk);
      out_cfg_in.smbus_value <= 10'h000;
      sm <= 10'h000;
      tick(3);
      chk(drv.level[3:0], {1'b0, x, 2'h0});
   endtask
   initial begin
      cfg_in = '0;
      cfg_in.digital_mode = 5'h0F;
      cfg_in.edge_mode = 5'h02;
      cfg_in.input_enable = 5'h07;
      cfg_in.glitch_cycles = 14'h0014;
      cfg_in.pulse_cycles = 14'h0006;
      out_cfg_in = '0;
      out_cfg_in.source[1] = SRC_SMBUS;
      out_cfg_in.source[2] = SRC_CLOCK;
      out_cfg_in.source[3] = SRC_RESERVED;
      out_cfg_in.drive[0] = DRV_CHARGE_PUMP;
      out_cfg_in.drive[9] = DRV_CHARGE_PUMP;
      out_cfg_in.smbus_value = 10'h002;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      tick(2);
      t_config();
      t_filter();
      t_logic(5'h1B);
      t_logic(5'h19);
      t_warn();
      t_outputs();
      final_report();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      error_cnt++;
      final_report();
   end
endmodule
